/* File: core/slx_params.svh */
// Purpose: constants for the serial link word exchange
// Assumes: included by its bare name
// Notes: setup offsets are word numbers on the setup port
`ifndef SLX_PARAMS_SVH
`define SLX_PARAMS_SVH

`define SETUP_MODE_OFS 8'hA0
`define SETUP_BAUD_OFS 8'hA1
`define SETUP_LINK_OFS 8'hA6
`define SETUP_OWN_OFS 8'hA7
`define SETUP_RESET 16'h0000

`define MODE_MSB 11
`define MODE_LSB 8
`define MODE_POLLING 4'h8
`define MODE_POLLED 4'h7
`define BAUD_MSB 7
`define BAUD_LSB 0
`define BAUD_HIGH_SPEED 8'h0A
`define METHOD_BIT 15
`define WORDS_MSB 7
`define WORDS_LSB 4
`define WORDS_DEFAULT 4'hA
`define HIGHEST_MSB 3
`define HIGHEST_LSB 0
`define OWN_MSB 3
`define OWN_LSB 0

`define AREA_FIRST 3100
`define AREA_LAST 3199
`define AREA_WORDS (`AREA_LAST - `AREA_FIRST + 1)

`define CLK_HZ 25000000
`define HS_BPS 115200
`define HS_BIT_CYCLES (`CLK_HZ / `HS_BPS)

`endif

/* File: core/slx_pkg.sv */
// Purpose: types for the serial link word exchange
// Assumes: nothing
// Notes: none
`default_nettype none
package slx_pkg;

    typedef enum logic [1:0] {ROLE_NONE, ROLE_POLLING, ROLE_POLLED} link_role_t;

    typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT, ST_REPLY} link_state_t;

    typedef struct packed {
        link_role_t role;
        logic polling_only;
        logic [3:0] words;
        logic [3:0] highest;
        logic [3:0] own;
        logic high_speed;
        logic [7:0] baud;
    } link_cfg_t;

    typedef struct packed {
        logic last;
        logic [3:0] unit;
        logic [6:0] index;
        logic [15:0] data;
    } link_word_t;

endpackage

`default_nettype wire

/* File: core/slx_setup_regs.sv */
// Purpose: setup words of the link and their decoded configuration
// Assumes: single clock, synchronous reset
// Notes: read data is combinational, registered by the parent
`timescale 1ns/1ps
`include "slx_params.svh"
`default_nettype none

module slx_setup_regs
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic setup_wr_i,
    input wire logic [7:0] setup_addr_i,
    input wire logic [15:0] setup_wdata_i,
    output logic [15:0] setup_rd_o,
    output slx_pkg::link_cfg_t cfg_o
);

    logic [15:0] port_mode_select;
    logic [15:0] port_baud_select;
    logic [15:0] link_method_words_units;
    logic [15:0] polled_own_number;
    logic [3:0] mode_field;
    logic [3:0] words_field;

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            port_mode_select <= `SETUP_RESET;
            port_baud_select <= `SETUP_RESET;
            link_method_words_units <= `SETUP_RESET;
            polled_own_number <= `SETUP_RESET;
        end
        else if (setup_wr_i)
        begin
            if (setup_addr_i == `SETUP_MODE_OFS)
                port_mode_select <= setup_wdata_i;
            else if (setup_addr_i == `SETUP_BAUD_OFS)
                port_baud_select <= setup_wdata_i;
            else if (setup_addr_i == `SETUP_LINK_OFS)
                link_method_words_units <= setup_wdata_i;
            else if (setup_addr_i == `SETUP_OWN_OFS)
                polled_own_number <= setup_wdata_i;
        end
    end

    always_comb
    begin
        if (setup_addr_i == `SETUP_MODE_OFS)
            setup_rd_o = port_mode_select;
        else if (setup_addr_i == `SETUP_BAUD_OFS)
            setup_rd_o = port_baud_select;
        else if (setup_addr_i == `SETUP_LINK_OFS)
            setup_rd_o = link_method_words_units;
        else if (setup_addr_i == `SETUP_OWN_OFS)
            setup_rd_o = polled_own_number;
        else
            setup_rd_o = 16'h0000;
    end

    assign mode_field = port_mode_select[`MODE_MSB:`MODE_LSB];
    assign words_field = link_method_words_units[`WORDS_MSB:`WORDS_LSB];

    always_comb
    begin
        if (mode_field == `MODE_POLLING)
            cfg_o.role = slx_pkg::ROLE_POLLING;
        else if (mode_field == `MODE_POLLED)
            cfg_o.role = slx_pkg::ROLE_POLLED;
        else
            cfg_o.role = slx_pkg::ROLE_NONE;
        cfg_o.polling_only = link_method_words_units[`METHOD_BIT];
        cfg_o.words = (words_field == 4'h0) ? `WORDS_DEFAULT : words_field;
        cfg_o.highest = link_method_words_units[`HIGHEST_MSB:`HIGHEST_LSB];
        cfg_o.own = polled_own_number[`OWN_MSB:`OWN_LSB];
        cfg_o.baud = port_baud_select[`BAUD_MSB:`BAUD_LSB];
        cfg_o.high_speed = (cfg_o.baud == `BAUD_HIGH_SPEED);
    end

    role_decode_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (cfg_o.role == slx_pkg::ROLE_POLLING) == (port_mode_select[11:8] == 4'h8))
        else $error("polling role does not follow mode field");

    words_default_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (setup_wr_i && setup_addr_i == 8'hA6 && setup_wdata_i[7:4] == 4'h0) |=> cfg_o.words == 4'hA)
        else $error("zero words field does not give ten words");

    method_sel_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (setup_wr_i && setup_addr_i == 8'hA6) |=> cfg_o.polling_only == $past(setup_wdata_i[15]))
        else $error("link method bit not taken");

endmodule

`default_nettype wire

/* File: core/serial_link_word_exchange.sv */
// Purpose: cyclic word sharing between one polling and up to eight polled stations
// Assumes: link words come from and go to a framer on the same clock
// Notes: areas of absent units keep stale contents, which counts as undefined
`timescale 1ns/1ps
`include "slx_params.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Mode field value 8 selects the polling-station role.
// - Mode field value 7 selects polled role; zero selects neither.
// - Baud codes 00-09 are standard; code 0A selects high speed.
// - High speed means every station runs at 115200 bits per second.
// - Method bit 15: 0 complete linking, 1 polling-station-only linking.
// - Words field sets link words per unit, 1 to 10; field values 11 to 15 are used unchanged.
// - Words field zero allocates ten words per unit.
// - Highest polled unit number taking part is 0 to 7; the 4-bit field lets the polling station poll up to unit 15.
// - A polled station takes its unit number from its own setup word.
// - Complete: polling block at 3100, unit k at 3100 plus N(k+1).
// - Polling-only: every polled station keeps its data right after polling block.
// - Polling-only: polling station leaves absent or terminal units' areas undefined.
// - Complete: every station mirrors all data; absent areas stay undefined.
// - Polling-only: polling gathers all, polled mirror only polling data.
// - At most one polling and eight polled stations, terminals included.
module serial_link_word_exchange
#(
    parameter int RESP_TIMEOUT = 2000
)
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic setup_wr_i,
    input wire logic [7:0] setup_addr_i,
    input wire logic [15:0] setup_wdata_i,
    output logic [15:0] setup_rdata_o,
    input wire logic loc_wr_i,
    input wire logic [6:0] loc_addr_i,
    input wire logic [15:0] loc_wdata_i,
    output logic [15:0] loc_rdata_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    output slx_pkg::link_word_t tx_word_o,
    input wire logic rx_valid_i,
    input wire slx_pkg::link_word_t rx_word_i,
    output logic high_speed_o,
    output logic [15:0] link_bit_cycles_o,
    output logic [7:0] unit_active_o,
    output logic link_cycle_o
);

    localparam int WAIT_MAX = RESP_TIMEOUT + 1;
    localparam int AREA_WORDS = `AREA_WORDS;

    slx_pkg::link_cfg_t cfg;
    logic [15:0] setup_rd;
    logic [15:0] area [0:AREA_WORDS-1];
    slx_pkg::link_state_t state;
    logic [3:0] unit;
    logic [6:0] idx;
    logic [15:0] timer;
    logic [6:0] send_len;
    logic [6:0] send_base;
    logic [6:0] rd_addr;
    logic [6:0] own_base;
    logic [3:0] out_unit;
    logic tx_load;
    logic last_load;
    logic rx_take;
    logic rx_store;
    logic [6:0] rx_addr;
    logic timed_out;
    logic advance;
    logic [15:0] wait_run;

    // start of unit k's block: N words per unit, polling block first
    function automatic logic [6:0] block_base(input logic [3:0] n, input logic [3:0] k);
        logic [7:0] p;
        p = {4'h0, n} * ({4'h0, k} + 8'h01);
        return p[6:0];
    endfunction

    slx_setup_regs u_setup
    (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .setup_wr_i(setup_wr_i),
        .setup_addr_i(setup_addr_i),
        .setup_wdata_i(setup_wdata_i),
        .setup_rd_o(setup_rd),
        .cfg_o(cfg)
    );

    ////////////////////////////////////////////////////////////////////////////
    // transmit plan and receive decode
    always_comb
    begin
        own_base = cfg.polling_only ? {3'b000, cfg.words} : block_base(cfg.words, cfg.own);
        if (cfg.role == slx_pkg::ROLE_POLLING)
        begin
            send_base = 7'h00;
            send_len = cfg.polling_only ? {3'b000, cfg.words}
                                        : block_base(cfg.words, cfg.highest + 4'h1);
            out_unit = unit;
        end
        else
        begin
            send_base = own_base;
            send_len = {3'b000, cfg.words};
            out_unit = cfg.own;
        end
        rd_addr = send_base + idx;
        last_load = (idx == send_len - 7'h01);
        tx_load = (state == slx_pkg::ST_SEND || state == slx_pkg::ST_REPLY) && (!tx_valid_o || tx_ready_i);
    end

    always_comb
    begin
        rx_take = 1'b0;
        rx_store = 1'b0;
        rx_addr = 7'h00;
        if (cfg.role == slx_pkg::ROLE_POLLING && state == slx_pkg::ST_WAIT)
        begin
            rx_take = rx_valid_i && rx_word_i.unit == unit;
            rx_store = rx_take && rx_word_i.index < {3'b000, cfg.words};
            rx_addr = block_base(cfg.words, unit) + rx_word_i.index;
        end
        else if (cfg.role == slx_pkg::ROLE_POLLED && state == slx_pkg::ST_IDLE)
        begin
            rx_take = rx_valid_i && rx_word_i.unit == cfg.own;
            rx_addr = rx_word_i.index;
            if (cfg.polling_only)
                rx_store = rx_take && rx_word_i.index < {3'b000, cfg.words};
            else
                rx_store = rx_take && rx_word_i.index < 7'(AREA_WORDS)
                           && !(rx_word_i.index >= own_base
                                && rx_word_i.index < own_base + {3'b000, cfg.words});
        end
    end

    assign timed_out = (timer == 16'(RESP_TIMEOUT - 1));
    assign advance = state == slx_pkg::ST_WAIT && ((rx_take && rx_word_i.last) || timed_out);

    ////////////////////////////////////////////////////////////////////////////
    // link sequencer
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            state <= slx_pkg::ST_IDLE;
            unit <= 4'h0;
            idx <= 7'h00;
            timer <= 16'h0000;
        end
        else if (cfg.role == slx_pkg::ROLE_NONE)
        begin
            state <= slx_pkg::ST_IDLE;
            idx <= 7'h00;
            timer <= 16'h0000;
        end
        else
        begin
            case (state)
                slx_pkg::ST_IDLE:
                begin
                    idx <= 7'h00;
                    timer <= 16'h0000;
                    if (cfg.role == slx_pkg::ROLE_POLLING)
                    begin
                        unit <= 4'h0;
                        state <= slx_pkg::ST_SEND;
                    end
                    else if (rx_take && rx_word_i.last)
                        state <= slx_pkg::ST_REPLY;
                end
                slx_pkg::ST_SEND:
                begin
                    if (tx_load)
                    begin
                        idx <= last_load ? 7'h00 : idx + 7'h01;
                        if (last_load)
                            state <= slx_pkg::ST_WAIT;
                    end
                end
                slx_pkg::ST_WAIT:
                begin
                    if (advance)
                    begin
                        timer <= 16'h0000;
                        if (unit >= cfg.highest)
                            state <= slx_pkg::ST_IDLE;
                        else
                        begin
                            unit <= unit + 4'h1;
                            state <= slx_pkg::ST_SEND;
                        end
                    end
                    else if (!tx_valid_o)
                        timer <= timer + 16'h0001;
                end
                slx_pkg::ST_REPLY:
                begin
                    if (tx_load)
                    begin
                        idx <= last_load ? 7'h00 : idx + 7'h01;
                        if (last_load)
                            state <= slx_pkg::ST_IDLE;
                    end
                end
                default:
                    state <= slx_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shared word area; link data wins over a local write to the same cycle
    always_ff @(posedge ref_clk_i)
    begin
        if (rx_store)
            area[rx_addr] <= rx_word_i.data;
        else if (loc_wr_i && loc_addr_i < 7'(AREA_WORDS))
            area[loc_addr_i] <= loc_wdata_i;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            loc_rdata_o <= 16'h0000;
        else
            loc_rdata_o <= (loc_addr_i < 7'(AREA_WORDS)) ? area[loc_addr_i] : 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit word register
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            tx_valid_o <= 1'b0;
            tx_word_o <= '0;
        end
        else if (tx_load)
        begin
            tx_valid_o <= 1'b1;
            tx_word_o <= {last_load, out_unit, idx, area[rd_addr]};
        end
        else if (tx_ready_i)
            tx_valid_o <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // status and rate outputs
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            unit_active_o <= 8'h00;
            link_cycle_o <= 1'b0;
        end
        else
        begin
            if (advance && unit < 4'h8)
                unit_active_o[unit[2:0]] <= !timed_out || (rx_take && rx_word_i.last);
            else if (cfg.role != slx_pkg::ROLE_POLLING)
                unit_active_o <= 8'h00;
            link_cycle_o <= advance && unit >= cfg.highest;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            setup_rdata_o <= 16'h0000;
            high_speed_o <= 1'b0;
            link_bit_cycles_o <= 16'h0000;
        end
        else
        begin
            setup_rdata_o <= setup_rd;
            high_speed_o <= cfg.high_speed;
            link_bit_cycles_o <= cfg.high_speed ? 16'(`HS_BIT_CYCLES) : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    high_speed_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        cfg.high_speed |=> high_speed_o && link_bit_cycles_o == 16'h00D9)
        else $error("high speed rate not driven");

    area_write_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (rx_store && state == slx_pkg::ST_WAIT)
        |=> area[$past(rx_addr)] == $past(rx_word_i.data))
        else $error("received word not stored in unit block");

    unit_order_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (state == slx_pkg::ST_WAIT ##1 state == slx_pkg::ST_SEND) |-> unit == $past(unit) + 4'h1)
        else $error("units not serviced in ascending order");

    own_reply_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (state == slx_pkg::ST_REPLY && tx_load) |=> tx_valid_o && tx_word_o.unit == $past(cfg.own))
        else $error("reply does not carry own unit number");

    reply_base_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (state == slx_pkg::ST_REPLY && cfg.polling_only) |-> rd_addr == {3'b000, cfg.words} + idx)
        else $error("polled data not read after polling block");

    // cycles spent waiting on a silent unit, bounded above
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            wait_run <= 16'h0000;
        else if (state == slx_pkg::ST_WAIT && !tx_valid_o)
            wait_run <= wait_run + 16'h0001;
        else
            wait_run <= 16'h0000;
    end

    wait_bound_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        wait_run < 16'(WAIT_MAX))
        else $error("absent unit stalls the link cycle");

    own_block_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (rx_store && cfg.role == slx_pkg::ROLE_POLLED && !cfg.polling_only)
        |-> (rx_addr < {3'b000, cfg.words} * ({3'b000, cfg.own} + 7'h01)
             || rx_addr >= {3'b000, cfg.words} * ({3'b000, cfg.own} + 7'h02)))
        else $error("mirror overwrote own block");

    polled_only_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (rx_store && cfg.role == slx_pkg::ROLE_POLLED && cfg.polling_only)
        |-> rx_addr < {3'b000, cfg.words})
        else $error("polled station stored beyond polling block");

    idle_role_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (cfg.role == slx_pkg::ROLE_NONE) |=> state == slx_pkg::ST_IDLE && !rx_store)
        else $error("link active without a role");

endmodule

`default_nettype wire

/* File: sim/slx_far_units.sv */
// Purpose: model of the polled stations on the far side of the link
// Assumes: same clock as the block; units present per present_i
// Notes: also sends polls when the block under test is a polled station
`timescale 1ns/1ps
`default_nettype none

module slx_far_units
(
    input wire logic clk_i,
    input wire logic [7:0] present_i,
    input wire logic [3:0] words_i,
    input wire logic slow_i,
    input wire logic tx_valid_i,
    input wire slx_pkg::link_word_t tx_word_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output slx_pkg::link_word_t rx_word_o
);
    slx_pkg::link_word_t log[$];
    slx_pkg::link_word_t w;
    logic got;

    function automatic logic [15:0] pat(input logic [3:0] u, input logic [6:0] i);
        return {4'hC, u, 1'b0, i};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // one word per cycle, then the line shows the inverse of its last value
    task automatic send(input logic [3:0] u, input int n, input logic [3:0] tag);
        for (int i = 0; i < n; i++)
        begin
            rx_valid_o = 1'b1;
            rx_word_o = {i == n - 1, u, 7'(i), pat(tag, 7'(i))};
            @(posedge clk_i);
            #1;
        end
        rx_valid_o = 1'b0;
        rx_word_o = ~rx_word_o;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        tx_ready_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_word_o = '0;
        forever
        begin
            @(posedge clk_i);
            got = tx_valid_i && tx_ready_o;
            w = tx_word_i;
            #1;
            if (got)
                log.push_back(w);
            tx_ready_o = slow_i ? !tx_ready_o : 1'b1;
            // only units 0 to 7 exist, each one present per present_i answers its own poll
            if (got && w.last && present_i[w.unit[2:0]] && w.unit < 4'h8)
            begin
                @(posedge clk_i);
                #1;
                send(w.unit, (words_i == 4'h0) ? 10 : int'(words_i), w.unit);
            end
        end
    end
endmodule

`default_nettype wire

/* File: sim/tb_serial_link_word_exchange.sv */
// Purpose: self-checking bench of the serial link word exchange
// Assumes: response timeout shortened to 20 cycles
// Notes: far side is the slx_far_units model
`timescale 1ns/1ps
`include "slx_params.svh"
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; $display("BAD %0t got %h exp %h", $time, a, b); end end

module tb_serial_link_word_exchange;
    logic ref_clk_i, reset_i, setup_wr_i, loc_wr_i, tx_valid_o, tx_ready_i, rx_valid_i;
    logic high_speed_o, link_cycle_o, slow;
    logic [7:0] setup_addr_i, unit_active_o, present;
    logic [15:0] setup_wdata_i, setup_rdata_o, loc_wdata_i, loc_rdata_o, link_bit_cycles_o, rd;
    logic [6:0] loc_addr_i;
    logic [3:0] words;
    slx_pkg::link_word_t tx_word_o, rx_word_i, e;
    int errors = 0;
    int checked = 0;

    serial_link_word_exchange #(.RESP_TIMEOUT(20)) u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .setup_wr_i(setup_wr_i), .setup_addr_i(setup_addr_i), .setup_wdata_i(setup_wdata_i),
        .setup_rdata_o(setup_rdata_o), .loc_wr_i(loc_wr_i), .loc_addr_i(loc_addr_i),
        .loc_wdata_i(loc_wdata_i), .loc_rdata_o(loc_rdata_o), .tx_valid_o(tx_valid_o),
        .tx_ready_i(tx_ready_i), .tx_word_o(tx_word_o), .rx_valid_i(rx_valid_i), .rx_word_i(rx_word_i),
        .high_speed_o(high_speed_o), .link_bit_cycles_o(link_bit_cycles_o),
        .unit_active_o(unit_active_o), .link_cycle_o(link_cycle_o));

    slx_far_units u_far (.clk_i(ref_clk_i), .present_i(present), .words_i(words), .slow_i(slow),
        .tx_valid_i(tx_valid_o), .tx_word_i(tx_word_o), .tx_ready_o(tx_ready_i),
        .rx_valid_o(rx_valid_i), .rx_word_o(rx_word_i));

    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge ref_clk_i);
            #1;
        end
    endtask

    task automatic wr_setup(input logic [7:0] a, input logic [15:0] d);
        tick(1);
        setup_wr_i = 1'b1;
        setup_addr_i = a;
        setup_wdata_i = d;
        tick(1);
        setup_wr_i = 1'b0;
    endtask

    task automatic rd_setup(input logic [7:0] a);
        tick(1);
        setup_addr_i = a;
        tick(1);
        rd = setup_rdata_o;
    endtask

    task automatic wr_area(input logic [6:0] a, input logic [15:0] d);
        tick(1);
        loc_wr_i = 1'b1;
        loc_addr_i = a;
        loc_wdata_i = d;
        tick(1);
        loc_wr_i = 1'b0;
    endtask

    task automatic rd_area(input int a);
        tick(1);
        loc_addr_i = 7'(a);
        tick(1);
        rd = loc_rdata_o;
    endtask

    task automatic wait_cycle();
        for (int i = 0; i < 1500 && link_cycle_o !== 1'b1; i++)
            tick(1);
    endtask

    task automatic wait_log(input int n);
        for (int i = 0; i < 100 && u_far.log.size() < n; i++)
            tick(1);
    endtask

    task automatic stop_link();
        wr_setup(`SETUP_MODE_OFS, 16'h0000);
        tick(40);
        u_far.log.delete();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] addrs [5] = '{8'hA0, 8'hA1, 8'hA6, 8'hA7, 8'hA2};
        `CHK(tx_valid_o, 1'b0)
        foreach (addrs[i])
        begin
            rd_setup(addrs[i]);
            `CHK(rd, `SETUP_RESET)
        end
        wr_setup(8'hA3, 16'hFFFF);
        rd_setup(8'hA3);
        `CHK(rd, 16'h0000)
        wr_setup(`SETUP_LINK_OFS, 16'h80F3);
        rd_setup(`SETUP_LINK_OFS);
        `CHK(rd, 16'h80F3)
    endtask

    task automatic t_baud();
        for (int c = 0; c <= 10; c++)
        begin
            wr_setup(`SETUP_BAUD_OFS, 16'(c));
            tick(2);
            `CHK(high_speed_o, c == 10)
            `CHK(link_bit_cycles_o, (c == 10) ? 16'(`HS_BIT_CYCLES) : 16'h0000)
        end
        wr_setup(`SETUP_BAUD_OFS, 16'h0000);
    endtask

    // n words per unit, units 0..hi polled, the whole burst checked in order
    task automatic t_polling(input int n, input int hi, input int len, input logic [15:0] cfg);
        u_far.log.delete();
        wr_setup(`SETUP_LINK_OFS, cfg);
        wr_setup(`SETUP_MODE_OFS, 16'h0800);
        wait_cycle();
        `CHK(link_cycle_o, 1'b1)
        `CHK(unit_active_o, present)
        for (int j = 0; j < (hi + 1) * len; j++)
        begin
            e = u_far.log[j];
            `CHK(e.unit, 4'(j / len))
            `CHK(e.index, 7'(j % len))
            `CHK(e.last, j % len == len - 1)
            if (j % len == 1)
                `CHK(e.data, 16'h2222)
        end
        stop_link();
        for (int k = 0; k <= hi; k++)
            for (int i = 0; i < n && present[k]; i++)
            begin
                rd_area(n * (k + 1) + i);
                `CHK(rd, u_far.pat(4'(k), 7'(i)))
            end
    endtask

    task automatic t_polled(input logic [15:0] cfg, input int own, input int n, input int at);
        present = 8'h00;
        wr_setup(`SETUP_LINK_OFS, cfg);
        wr_setup(`SETUP_OWN_OFS, 16'(own));
        wr_area(7'(at), 16'hBEEF);
        wr_setup(`SETUP_MODE_OFS, 16'h0700);
        u_far.log.delete();
        tick(1);
        u_far.send(4'(own + 1), n, 4'h5);
        tick(10);
        `CHK(u_far.log.size(), 0)
        u_far.send(4'(own), n, 4'(own));
        wait_log(1);
        e = u_far.log[0];
        `CHK(e.unit, 4'(own))
        `CHK(e.data, 16'hBEEF)
        `CHK(e.last, 1'b1)
        stop_link();
        for (int i = 0; i < n; i++)
        begin
            rd_area(i);
            `CHK(rd, (i == at) ? 16'hBEEF : u_far.pat(4'(own), 7'(i)))
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    initial
    begin
        #(20000 * 40);
        errors++;
        wrap_up();
    end

    initial
    begin
        reset_i = 1'b1;
        {setup_wr_i, loc_wr_i, slow} = 3'b000;
        setup_addr_i = 8'h00;
        setup_wdata_i = 16'h0000;
        loc_addr_i = 7'h00;
        loc_wdata_i = 16'h0000;
        present = 8'h0B;
        words = 4'h2;
        tick(5);
        reset_i = 1'b0;
        t_reset();
        t_baud();
        wr_area(7'h01, 16'h2222);
        t_polling(2, 3, 10, 16'h0023);
        present = 8'h03;
        words = 4'h0;
        slow = 1'b1;
        wr_area(7'h01, 16'h2222);
        t_polling(10, 1, 10, 16'h8001);
        slow = 1'b0;
        words = 4'h1;
        t_polled(16'h0010, 2, 4, 3);
        t_polled(16'h8010, 4, 1, 1);
        wrap_up();
    end
endmodule

`default_nettype wire
